// ===== inc/vsd_params.svh
// Constants for the serial display core
`ifndef VSD_PARAMS_SVH
`define VSD_PARAMS_SVH
`define VSD_CHIP_ADDR 8'h5a
`define VSD_CHAR_DEPTH 64
`define VSD_EXTRA_DEPTH 16
`define VSD_USER_DEPTH 8
`define VSD_ROM_DEPTH 160
`define VSD_ROM_FIRST 8'h10
`define VSD_DIGITS 16
`define VSD_GLYPH_BITS 35
`define VSD_FRAME_BITS 64
`define VSD_SHORT_ADDR_LSB 32
`define VSD_SHORT_INSTR_LSB 40
`define VSD_LONG_ADDR_LSB 0
`define VSD_LONG_INSTR_LSB 8
`define VSD_LONG_OP_MSB 55
`define VSD_LONG_SLOT_LSB 48
`define VSD_OP_ONOFF 4'h1
`define VSD_OP_SHIFT 4'h2
`define VSD_OP_GRID 4'h3
`define VSD_OP_SETADDR 4'h4
`define VSD_OP_DIMMER 4'h5
`define VSD_OP_CHARWR 4'h6
`define VSD_OP_EXTRAWR 4'h7
`define VSD_OP_BLINK 3'h5
`define VSD_OP_GLYPHWR 3'h4
`define VSD_CLK_HZ 50000000
`define VSD_BLINK_STEP_MS 100
`define VSD_BLINK_STEP_CYCLES (`VSD_CLK_HZ / 1000 * `VSD_BLINK_STEP_MS)
`endif

// ===== inc/vsd_pkg.sv
// Types shared by the serial display core
package vsd_pkg;
  typedef logic [34:0] vsd_glyph_t;
  typedef logic [5:0] vsd_char_addr_t;
  typedef logic [3:0] vsd_extra_addr_t;
  typedef logic [15:0] vsd_digit_mask_t;
endpackage

// ===== verilog/vsd_core.sv
// Serial-commanded 16-digit dot-matrix display controller core
//
// Overview of operation
// RQ1 - Character-code RAM, 64 entries of 8 bits
// RQ2 - Digits read consecutive char addresses from base
// RQ3 - Matrix shift moves char base, wraps 64
// RQ4 - Extra RAM 16x8 drives extra outputs directly
// RQ5 - Digits read consecutive extra addresses from base
// RQ6 - Extra shift moves extra base, wraps 16
// RQ7 - Glyph ROM of 160 patterns, 35 bits
// RQ8 - Writable user glyph RAM of 8 patterns
// RQ9 - Reset low blanks every anode and grid
// RQ10 - RAMs and intensity registers not reset
// RQ11 - Host initialises before enabling display
// RQ12 - Host sends grid, intensity, on/off together
// RQ13 - Frame is chip address then instruction
// RQ14 - Respond only to own chip address
// RQ15 - Glyph write frame carries 56-bit field
// RQ16 - Sample on clock rise, commit on latch fall
// RQ17 - Host waits for command completion
// RQ18 - Blink command decoded by opcode 101
// RQ19 - Matrix/extra select bits choose blinking data
// RQ20 - Period code selects blink period, 0 stops
// RQ21 - Host may blink precisely via on/off
// RQ22 - Address counter supplies both RAM bases; code keeps separate cbase_r and ebase_r registers
// RQ23 - Set-address loads both bases together
// RQ24 - Foreign chip address frames change nothing
// RQ25 - Scan enabled digits from glyph and extra
`timescale 1ns/10ps
`include "vsd_params.svh"
module vsd_core #(
  parameter int unsigned BLINK_STEP_CYCLES = `VSD_BLINK_STEP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic serial_shift_clock,
  input wire logic serial_data_input,
  input wire logic frame_latch_enable,
  output logic [34:0] matrix_anode,
  output logic [7:0] extra_anode,
  output vsd_pkg::vsd_digit_mask_t grid_out
);
  import vsd_pkg::*;

  function automatic logic [5:0] blink_mult(input logic [2:0] code);
    case (code)
      3'h6: blink_mult = 6'h08;
      3'h7: blink_mult = 6'h0a;
      default: blink_mult = {3'h0, code};
    endcase
  endfunction

  // Arbitrary stand-in character set, not a real font
  function automatic vsd_glyph_t glyph_rom(input logic [7:0] code);
    logic [7:0] idx;
    idx = code - `VSD_ROM_FIRST;
    if (code < `VSD_ROM_FIRST || idx >= 8'(`VSD_ROM_DEPTH))
      glyph_rom = '0;
    else
      glyph_rom = {idx[2:0], idx, ~idx, idx, ~idx};
  endfunction

  // Link domain: shift register on the host's clock
  logic [63:0] shift_r;
  logic [63:0] shift_nxt;
  // Free-running bit count; stale bits alone cannot fake a frame
  logic [6:0] nbits_r;
  logic [6:0] nbits_nxt;
  always_comb
  begin
    // RQ16 sample on rise
    shift_nxt = {serial_data_input, shift_r[63:1]};
    nbits_nxt = nbits_r + 7'h01;
  end
  always_ff @(posedge serial_shift_clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_r <= '0;
      nbits_r <= '0;
    end
    else
    begin
      shift_r <= shift_nxt;
      nbits_r <= nbits_nxt;
    end
  end

  // Latch enable crossing; shift data is still while it is low
  logic ce_s1_r, ce_s2_r, ce_s3_r;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ce_s1_r <= 1'b0;
      ce_s2_r <= 1'b0;
      ce_s3_r <= 1'b0;
    end
    else
    begin
      ce_s1_r <= frame_latch_enable;
      ce_s2_r <= ce_s1_r;
      ce_s3_r <= ce_s2_r;
    end
  end

  logic [7:0] char_ram [`VSD_CHAR_DEPTH];
  logic [7:0] extra_ram [`VSD_EXTRA_DEPTH];
  vsd_glyph_t user_ram [`VSD_USER_DEPTH];

  // Command decode state
  logic commit;
  logic long_hit, short_hit;
  logic [23:0] ins;
  logic [55:0] lins;
  logic [6:0] flen;
  logic [6:0] nbits_seen_r, nbits_seen_nxt;
  vsd_char_addr_t cbase_r, cbase_nxt;
  vsd_extra_addr_t ebase_r, ebase_nxt;
  logic disp_on_r, disp_on_nxt;
  logic show_m_r, show_m_nxt, show_a_r, show_a_nxt;
  vsd_digit_mask_t dig_en_r, dig_en_nxt;
  logic [3:0] gridn_r, gridn_nxt;
  logic [7:0] duty_r, duty_nxt;
  logic blk_m_r, blk_m_nxt, blk_a_r, blk_a_nxt;
  logic [2:0] blk_code_r, blk_code_nxt;
  vsd_digit_mask_t blk_dig_r, blk_dig_nxt;
  logic char_we, extra_we, user_we;

  always_comb
  begin
    // RQ16 commit on latch fall
    commit = ce_s3_r & ~ce_s2_r;
    lins = shift_r[63:`VSD_LONG_INSTR_LSB];
    ins = shift_r[63:`VSD_SHORT_INSTR_LSB];
    // RQ24 length since last latch
    flen = nbits_r - nbits_seen_r;
    nbits_seen_nxt = commit ? nbits_r : nbits_seen_r;
    // RQ15 long glyph frame
    long_hit = commit
      && flen == 7'(`VSD_FRAME_BITS)
      && shift_r[`VSD_LONG_ADDR_LSB +: 8] == `VSD_CHIP_ADDR
      && lins[`VSD_LONG_OP_MSB -: 3] == `VSD_OP_GLYPHWR;
    // RQ13 RQ14 RQ24 own address only
    short_hit = commit && !long_hit
      && flen == 7'(`VSD_FRAME_BITS - `VSD_SHORT_ADDR_LSB)
      && shift_r[`VSD_SHORT_ADDR_LSB +: 8] == `VSD_CHIP_ADDR;
    cbase_nxt = cbase_r;
    ebase_nxt = ebase_r;
    disp_on_nxt = disp_on_r;
    show_m_nxt = show_m_r;
    show_a_nxt = show_a_r;
    dig_en_nxt = dig_en_r;
    gridn_nxt = gridn_r;
    duty_nxt = duty_r;
    blk_m_nxt = blk_m_r;
    blk_a_nxt = blk_a_r;
    blk_code_nxt = blk_code_r;
    blk_dig_nxt = blk_dig_r;
    char_we = 1'b0;
    extra_we = 1'b0;
    user_we = long_hit;
    if (short_hit)
    begin
      // RQ18 blink opcode
      if (ins[23:21] == `VSD_OP_BLINK)
      begin
        blk_m_nxt = ins[20];
        blk_a_nxt = ins[19];
        blk_code_nxt = ins[18:16];
        blk_dig_nxt = ins[15:0];
      end
      else
        unique case (ins[23:20])
          `VSD_OP_ONOFF:
          begin
            show_m_nxt = ins[18];
            show_a_nxt = ins[17];
            disp_on_nxt = ins[16];
            dig_en_nxt = ins[15:0];
          end
          `VSD_OP_SHIFT:
          begin
            // RQ3 char base wraps
            if (ins[18])
              cbase_nxt = ins[16] ? cbase_r + 6'h01 : cbase_r - 6'h01;
            // RQ6 extra base wraps
            if (ins[17])
              ebase_nxt = ins[16] ? ebase_r + 4'h1 : ebase_r - 4'h1;
          end
          `VSD_OP_GRID: gridn_nxt = ins[19:16];
          // RQ23 both bases load
          `VSD_OP_SETADDR:
          begin
            ebase_nxt = ins[19:16];
            cbase_nxt = ins[13:8];
          end
          `VSD_OP_DIMMER: duty_nxt = ins[15:8];
          `VSD_OP_CHARWR: char_we = 1'b1;
          `VSD_OP_EXTRAWR: extra_we = 1'b1;
          default: ;
        endcase
    end
  end

  // RQ10 intensity and grid count not reset
  always_ff @(posedge ref_clk)
  begin
    gridn_r <= gridn_nxt;
    duty_r <= duty_nxt;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cbase_r <= '0;
      ebase_r <= '0;
      disp_on_r <= 1'b0;
      show_m_r <= 1'b0;
      show_a_r <= 1'b0;
      dig_en_r <= '0;
      blk_m_r <= 1'b0;
      blk_a_r <= 1'b0;
      blk_code_r <= '0;
      blk_dig_r <= '0;
      nbits_seen_r <= '0;
    end
    else
    begin
      // RQ22 char and extra bases held in separate registers
      cbase_r <= cbase_nxt;
      ebase_r <= ebase_nxt;
      disp_on_r <= disp_on_nxt;
      show_m_r <= show_m_nxt;
      show_a_r <= show_a_nxt;
      dig_en_r <= dig_en_nxt;
      blk_m_r <= blk_m_nxt;
      blk_a_r <= blk_a_nxt;
      blk_code_r <= blk_code_nxt;
      blk_dig_r <= blk_dig_nxt;
      nbits_seen_r <= nbits_seen_nxt;
    end
  end

  // RQ1 RQ4 RQ8 RQ10 memory writes, contents unreset
  always_ff @(posedge ref_clk)
  begin
    if (char_we)
      char_ram[ins[13:8]] <= ins[7:0];
    if (extra_we)
      extra_ram[ins[19:16]] <= ins[15:8];
    if (user_we)
      user_ram[lins[`VSD_LONG_SLOT_LSB +: 3]] <= lins[34:0];
  end

  // Blink timer; a new period code keeps the running count, code 0 or the end of each half period clears it
  logic [31:0] blk_cnt_r, blk_cnt_nxt;
  logic blk_phase_r, blk_phase_nxt;
  logic [37:0] blk_half;
  always_comb
  begin
    // RQ20 period from code
    blk_half = 38'(BLINK_STEP_CYCLES / 2) * 38'(blink_mult(blk_code_r));
    blk_cnt_nxt = blk_cnt_r + 32'h1;
    blk_phase_nxt = blk_phase_r;
    if (blk_code_r == 3'h0)
    begin
      blk_cnt_nxt = '0;
      blk_phase_nxt = 1'b0;
    end
    else if (38'(blk_cnt_r) + 38'h1 >= blk_half)
    begin
      blk_cnt_nxt = '0;
      blk_phase_nxt = ~blk_phase_r;
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      blk_cnt_r <= '0;
      blk_phase_r <= 1'b0;
    end
    else
    begin
      blk_cnt_r <= blk_cnt_nxt;
      blk_phase_r <= blk_phase_nxt;
    end
  end

  // Scan: one 256-tick slot per digit, duty sets the lit part
  logic [3:0] dig_r, dig_nxt;
  logic [7:0] tick_r, tick_nxt;
  logic [3:0] last_dig;
  vsd_char_addr_t caddr;
  vsd_extra_addr_t eaddr;
  logic [7:0] code;
  vsd_glyph_t pat;
  logic lit, blank_m, blank_a;
  logic [34:0] m_nxt;
  logic [7:0] a_nxt;
  vsd_digit_mask_t g_nxt;
  always_comb
  begin
    last_dig = gridn_r - 4'h1;
    tick_nxt = tick_r + 8'h01;
    dig_nxt = dig_r;
    if (tick_r == 8'hff)
      dig_nxt = (dig_r == last_dig) ? 4'h0 : dig_r + 4'h1;
    // RQ2 RQ5 consecutive addresses
    caddr = cbase_r + {2'b00, dig_r};
    eaddr = ebase_r + dig_r;
    code = char_ram[caddr];
    // RQ7 RQ8 glyph source
    if (code < 8'(`VSD_USER_DEPTH))
      pat = user_ram[code[2:0]];
    else
      pat = glyph_rom(code);
    // RQ19 blink selection
    blank_m = blk_phase_r && blk_m_r && blk_dig_r[dig_r];
    blank_a = blk_phase_r && blk_a_r && blk_dig_r[dig_r];
    lit = disp_on_r && dig_en_r[dig_r] && tick_r < duty_r;
    // RQ25 drive scanned digit
    m_nxt = (lit && show_m_r && !blank_m) ? pat : '0;
    a_nxt = (lit && show_a_r && !blank_a) ? extra_ram[eaddr] : '0;
    g_nxt = '0;
    g_nxt[dig_r] = lit;
  end
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    // RQ9 reset blanks outputs
    if (!reset_n)
    begin
      dig_r <= '0;
      tick_r <= '0;
      matrix_anode <= '0;
      extra_anode <= '0;
      grid_out <= '0;
    end
    else
    begin
      dig_r <= dig_nxt;
      tick_r <= tick_nxt;
      matrix_anode <= m_nxt;
      extra_anode <= a_nxt;
      grid_out <= g_nxt;
    end
  end
endmodule

// ===== dv/vsd_core_props.sv
// Port checker for the serial display core
`timescale 1ns/10ps
module vsd_core_props #(
  parameter int unsigned BLINK_STEP_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic frame_latch_enable,
  input wire logic [34:0] matrix_anode,
  input wire logic [7:0] extra_anode,
  input wire vsd_pkg::vsd_digit_mask_t grid_out
);
  import vsd_pkg::*;
  logic le_r;
  logic cmd_seen_r;
  logic [8:0] lit_r;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // Lit run length, since one slot allows 255
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      le_r <= 1'b0;
      cmd_seen_r <= 1'b0;
      lit_r <= 9'h0;
    end
    else
    begin
      le_r <= frame_latch_enable;
      cmd_seen_r <= cmd_seen_r | (le_r & ~frame_latch_enable);
      lit_r <= (|{matrix_anode, extra_anode}) ? lit_r + 9'h1 : 9'h0;
    end
  end
  a_release_dark: assert property ($rose(reset_n) |->
    grid_out == 16'h0 && matrix_anode == 35'h0 && extra_anode == 8'h0)
    else $error("lit at reset release");
  a_off_until_cmd: assert property (!cmd_seen_r |-> grid_out == 16'h0)
    else $error("grid lit before any command");
  a_grid_onehot: assert property ($onehot0(grid_out))
    else $error("several grids lit");
  a_matrix_dark: assert property (grid_out == 16'h0 |-> !(|matrix_anode))
    else $error("matrix lit without grid");
  a_extra_dark: assert property (grid_out == 16'h0 |-> extra_anode == 8'h0)
    else $error("extra lit without grid");
  a_grid_steady: assert property (grid_out != 16'h0 &&
    $past(grid_out) != 16'h0 |-> $stable(grid_out))
    else $error("grid moved without gap");
  a_lit_bounded: assert property (lit_r <= 9'h0ff)
    else $error("anodes lit past one slot");
  a_pulse_ends: assert property ($rose(|grid_out) |->
    ##[1:255] grid_out == 16'h0)
    else $error("grid pulse too long");
endmodule
bind vsd_core vsd_core_props #(.BLINK_STEP_CYCLES(BLINK_STEP_CYCLES)) u_props (
  .ref_clk(ref_clk),
  .reset_n(reset_n),
  .frame_latch_enable(frame_latch_enable),
  .matrix_anode(matrix_anode),
  .extra_anode(extra_anode),
  .grid_out(grid_out)
);

// ===== dv/vsd_host_model.sv
// Host model driving the serial command link
`timescale 1ns/10ps
module vsd_host_model (
  output logic serial_shift_clock,
  output logic serial_data_input,
  output logic frame_latch_enable
);
  initial
  begin
    serial_shift_clock = 1'b0;
    serial_data_input = 1'b0;
    frame_latch_enable = 1'b0;
  end
  task automatic send(input logic [63:0] f, input int n);
    frame_latch_enable = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      serial_data_input = f[i];
      #31.25 serial_shift_clock = 1'b1;
      #62.5 serial_shift_clock = 1'b0;
      #31.25;
    end
    frame_latch_enable = 1'b0;
    // Idle data line shows junk, not the last bit
    serial_data_input = ~serial_data_input;
    #1000;
  endtask
endmodule

// ===== dv/vsd_serial_display_core_bench.sv
// Self-checking bench for the serial display core
`timescale 1ns/10ps
`include "vsd_params.svh"
module vsd_serial_display_core_bench;
  import vsd_pkg::*;
  logic ref_clk;
  logic reset_n;
  logic sck;
  logic sdi;
  logic le;
  logic [34:0] matrix_anode;
  logic [7:0] extra_anode;
  vsd_digit_mask_t grid_out;
  int errors;
  int checks_done;
  int mo;
  int xo;
  int lt;
  logic [31:0] seed;
  logic [31:0] r;
  vsd_glyph_t ug [8];
  logic [7:0] cr [64];
  logic [7:0] xr [16];
  vsd_char_addr_t cb;
  vsd_extra_addr_t xb;
  vsd_core #(.BLINK_STEP_CYCLES(20)) DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .serial_shift_clock(sck),
    .serial_data_input(sdi), .frame_latch_enable(le),
    .matrix_anode(matrix_anode), .extra_anode(extra_anode),
    .grid_out(grid_out)
  );
  vsd_host_model host (
    .serial_shift_clock(sck), .serial_data_input(sdi),
    .frame_latch_enable(le)
  );
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [63:0] cmd(input logic [3:0] op,
                                      input logic [19:0] lo);
    return {32'h0, op, lo, `VSD_CHIP_ADDR};
  endfunction
  task automatic chk(input logic [34:0] seen, input logic [34:0] exp,
                     input string what);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wgrid(input bit on);
    int w;
    w = 0;
    while ((grid_out !== 16'h0) != on && w < 600)
    begin
      @(negedge ref_clk);
      w++;
    end
  endtask
  function automatic int gidx();
    int k;
    k = 0;
    for (int i = 0; i < 16; i++)
      if (grid_out[i] === 1'b1)
        k = i;
    return k;
  endfunction
  // Codes past the user slots and outside the glyph set stay blank
  function automatic vsd_glyph_t exp_mat(input int d);
    logic [7:0] c;
    c = cr[6'(cb + d)];
    return (c < 8'(`VSD_USER_DEPTH)) ? ug[c[2:0]] : '0;
  endfunction
  function automatic logic [34:0] exp_ext(input int d);
    return 35'(xr[4'(xb + d)]);
  endfunction
  task automatic scan();
    int d;
    int p;
    p = -1;
    repeat (16)
    begin
      wgrid(1'b1);
      d = gidx();
      if (p >= 0)
        chk(35'(d), 35'((p + 1) % 16), "dig");
      p = d;
      @(negedge ref_clk);
      chk(matrix_anode, exp_mat(d), "mat");
      chk(35'(extra_anode), exp_ext(d), "ext");
      wgrid(1'b0);
    end
  endtask
  // Counts dark matrix on non-blank digits, dark extra, lit cycles
  task automatic watch();
    int d;
    mo = 0;
    xo = 0;
    lt = 0;
    repeat (600)
    begin
      @(negedge ref_clk);
      if (grid_out !== 16'h0)
      begin
        d = gidx();
        lt++;
        mo += int'(matrix_anode === 35'h0 && exp_mat(d) !== 35'h0);
        xo += int'(extra_anode === 8'h0);
      end
    end
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Frames plus scans need about 60000 cycles
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    errors++;
    print_verdict();
  end
  initial
  begin
    errors = 0;
    checks_done = 0;
    seed = 32'ha036e35b;
    reset_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(negedge ref_clk);
    chk(35'(grid_out), 35'h0, "grid");
    host.send(cmd(4'ha, 20'h0), 32);
    for (int i = 0; i < 64; i++)
    begin
      cr[i] = 8'(rnd() & 32'h7);
      if (i % 16 == 5)
        cr[i] = cr[i] | 8'h08;
      if (i % 16 == 9)
        cr[i] = cr[i] | 8'hb8;
      host.send(cmd(4'h6, {6'h0, i[5:0], cr[i]}), 32);
    end
    for (int i = 0; i < 16; i++)
    begin
      xr[i] = 8'(rnd()) | 8'h01;
      host.send(cmd(4'h7, {i[3:0], xr[i], 8'h0}), 32);
    end
    for (int i = 0; i < 8; i++)
    begin
      ug[i] = 35'({rnd(), rnd()}) | 35'h1;
      host.send({3'b100, 2'b0, i[2:0], 13'h0, ug[i], `VSD_CHIP_ADDR}, 64);
    end
    cb = 6'h3f;
    xb = 4'hf;
    host.send(cmd(4'h4, {xb, 2'h0, cb, 8'h0}), 32);
    host.send(cmd(4'h3, 20'h0), 32);
    host.send(cmd(4'h5, 20'h0ff00), 32);
    host.send(cmd(4'h1, 20'h7ffff), 32);
    scan();
    // Foreign chip address must leave char RAM alone
    r = (cr[cb + 6'h08] == 8'h00) ? 32'h1 : 32'h0;
    host.send(cmd(4'h6, {6'h0, cb + 6'h08, r[7:0]}) ^ 64'hff, 32);
    for (int i = 0; i < 3; i++)
    begin
      r = (i == 0) ? 32'h7 : rnd();
      host.send(cmd(4'h2, {1'b0, r[2:0], 16'h0}), 32);
      if (r[2]) cb = r[0] ? cb + 6'h1 : cb - 6'h1;
      if (r[1]) xb = r[0] ? xb + 4'h1 : xb - 4'h1;
      scan();
    end
    host.send(cmd(4'h1, 20'h3ffff), 32);
    watch();
    chk(35'(mo > 0), 35'h1, "moff");
    chk(35'(xo), 35'h0, "aon");
    host.send(cmd(4'h1, 20'h6ffff), 32);
    watch();
    chk(35'(lt), 35'h0, "dark");
    host.send(cmd(4'h1, 20'h7ffff), 32);
    scan();
    for (int c = 0; c < 8; c++)
    begin
      host.send(cmd({3'b101, c[0]}, {c[1], c[2:0], 16'hffff}), 32);
      watch();
      chk(35'(mo > 0), 35'(c[0]), "mblink");
      chk(35'(xo > 0), 35'(c[1]), "xblink");
    end
    @(posedge ref_clk);
    reset_n <= 1'b0;
    @(negedge ref_clk);
    chk(35'(grid_out), 35'h0, "grid");
    chk(matrix_anode, 35'h0, "mat");
    chk(35'(extra_anode), 35'h0, "ext");
    print_verdict();
  end
endmodule
